// ### verilog/scd_pkg.sv
// Shared constants and types for the serial configuration port and its master
package scd_pkg;
  // Device register addresses
  localparam logic [7:0] A_CFG   = 8'h00;
  localparam logic [7:0] A_NUL   = 8'h40;
  localparam logic [7:0] A_DCV_A = 8'h41;
  localparam logic [7:0] A_DCV_B = 8'h42;
  localparam logic [7:0] A_ALM   = 8'h45;
  localparam logic [7:0] A_UP_A  = 8'h47;
  localparam logic [7:0] A_UP_B  = 8'h48;
  localparam logic [7:0] A_LO_A  = 8'h49;
  localparam logic [7:0] A_LO_B  = 8'h4A;
  localparam logic [7:0] A_DW_A  = 8'h4B;
  localparam logic [7:0] A_DW_B  = 8'h4C;
  localparam logic [7:0] A_XFER  = 8'hFF;
  // Index of the first byte of each shadowed field
  localparam logic [2:0] I_NUL = 3'h0;
  localparam logic [2:0] I_ALM = 3'h1;
  localparam logic [2:0] I_UP  = 3'h2;
  localparam logic [2:0] I_LO  = 3'h4;
  localparam logic [2:0] I_DW  = 3'h6;
  // Field positions
  localparam int B_LSB_FIRST = 6;
  localparam int B_FREEZE    = 6;
  localparam int B_NUL_EN    = 1;
  localparam int K_LO        = 2;
  localparam int K_HI        = 5;
  localparam int B_ALM_EN    = 0;
  localparam int B_XFER      = 0;
  localparam int B_RNW       = 15;
  localparam int B_LEN_HI    = 14;
  localparam int B_LEN_LO    = 13;
  localparam logic [3:0] K_MAX  = 4'hD;
  localparam logic [4:0] K_BASE = 5'h0E;
  // Reset values
  localparam logic [7:0]  R_BYTE  = 8'h00;
  localparam logic [15:0] R_DWELL = 16'h0001;
  // Sample path
  localparam int SMP_W   = 14;
  localparam int OUT_W   = 16;
  localparam int ALM_LAT = 7;
  localparam int DC_FRAC = 30;
  localparam int ACC_W   = 48;
  // Master bus map
  localparam logic [7:0] W_INSTR = 8'h00;
  localparam logic [7:0] W_TX    = 8'h04;
  localparam logic [7:0] W_RX    = 8'h08;
  localparam logic [7:0] W_STAT  = 8'h0C;
  localparam logic [7:0] W_CFG   = 8'h10;
  // Link timing
  localparam int CLK_NS   = 10;
  localparam int SCLK_NS  = 160;
  localparam int HALF_CYC = SCLK_NS / (2 * CLK_NS);
  localparam logic [3:0] HC_END  = 4'(HALF_CYC - 1);
  localparam logic [3:0] GAP_END = 4'(2 * HALF_CYC - 1);
  // State encodings
  typedef enum logic {PH_INSTR = 1'b0, PH_DATA = 1'b1} scd_phase_t;
  typedef enum logic [2:0]
  {
    M_IDLE = 3'b000,
    M_LEAD = 3'b001,
    M_LOW  = 3'b010,
    M_HIGH = 3'b011,
    M_GAP  = 3'b100
  } scd_mst_t;
endpackage : scd_pkg

// ### verilog/scd_link_if.sv
// Three-wire link between the serial master and the device end
`timescale 1ns/1ns
`default_nettype none
interface scd_link_if;
  logic cs_n;
  logic sclk;
  logic m_sdo;
  logic m_oe;
  logic d_sdo;
  logic d_oe;
  logic sdio;
  // Shared data wire; an undriven wire reads high as if pulled up
  assign sdio = d_oe ? d_sdo : (m_oe ? m_sdo : 1'b1);
  modport master (output cs_n, output sclk, output m_sdo, output m_oe, input sdio);
  modport device (input cs_n, input sclk, input sdio, output d_sdo, output d_oe);
endinterface : scd_link_if
`default_nettype wire

// ### verilog/scd_device.sv
// Device end: serial configuration port, threshold alarm and offset nulling filter
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Alarm held until dwell below lower threshold
// - 16-bit lower threshold versus sample magnitude
// - Threshold code over 2^13 is fraction
// - Dwell count 1 to 65535 sample cycles
// - Filter corner from k, valid 0..13
// - Live 16-bit correction readable in two bytes
// - Freeze holds correction, clear resumes updating
// - Enable subtracts correction from output data
// - Frame starts at first rise after select
// - Select held low keeps port streaming
// - Select high between bytes keeps position, except when streaming
// - Select high releases the data pin
// - 16-bit instruction, then length-selected data
// - Byte words, read/write in bit 15, sent first only in MSB-first order
// - Pin turns output at readback data
// - Bit order MSB first, LSB selectable
// - Master clock times all serial transfers
// - Master keeps port quiet during capture
// - Shadowed writes applied by transfer bit
// - Upper threshold sets alarm, seven-cycle latency
module scd_device
(
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  // Three-wire link
  scd_link_if.device                     link,
  // Converter samples, twos complement
  input  wire logic [scd_pkg::SMP_W-1:0] sample_in,
  // Corrected samples and alarm
  output logic      [scd_pkg::OUT_W-1:0] sample_out,
  output logic                           threshold_alarm_flag
);
  import scd_pkg::*;

  // Link synchronisers and edge history
  logic [1:0]       cs_s_q;
  logic [1:0]       ck_s_q;
  logic [1:0]       di_s_q;
  logic             ck_prev_q;
  logic             cs_prev_q;
  logic             ck_rise;
  logic             ck_fall;
  logic             cs_low;
  logic             cs_fall;
  logic             sdi;
  // Serial frame state
  scd_phase_t       ph_q;
  scd_phase_t       ph_d;
  logic [3:0]       cnt_q;
  logic [3:0]       cnt_d;
  logic [15:0]      ins_q;
  logic [15:0]      ins_d;
  logic [7:0]       adr_q;
  logic [7:0]       adr_d;
  logic [7:0]       rx_q;
  logic [7:0]       rx_d;
  logic [7:0]       rb_q;
  logic [7:0]       rb_d;
  logic [1:0]       left_q;
  logic [1:0]       left_d;
  logic             rnw_q;
  logic             rnw_d;
  logic             strm_q;
  logic             strm_d;
  logic             sdo_q;
  logic             sdo_d;
  logic             oe_q;
  logic             oe_d;
  logic             lsb;
  logic             wr_en;
  logic [7:0]       wr_dat;
  // Register file: shadow and active copies
  logic [7:0]       cfg_q;
  logic [7:0]       cfg_d;
  logic [7:0][7:0]  sh_q;
  logic [7:0][7:0]  sh_d;
  logic [7:0][7:0]  act_q;
  logic [7:0][7:0]  act_d;
  // Sample path
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic [ACC_W-1:0] xa;
  logic [ACC_W-1:0] err;
  logic [15:0]      x16;
  logic [15:0]      mag;
  logic [15:0]      dcv;
  logic [15:0]      up_thr;
  logic [15:0]      lo_thr;
  logic [15:0]      dwell;
  logic [3:0]       k;
  logic [4:0]       shamt;
  logic [ALM_LAT-2:0] hit_q;
  logic [ALM_LAT-2:0] hit_d;
  logic [ALM_LAT-2:0] blw_q;
  logic [ALM_LAT-2:0] blw_d;
  logic signed [ACC_W-1:0] step;
  logic [3:0]       widx;
  logic [15:0]      dwc_q;
  logic [15:0]      dwc_d;
  logic             flag_q;
  logic             flag_d;
  logic [15:0]      out_q;
  logic [15:0]      out_d;

  // Shadow index of an address; 4'h8 means not shadowed
  function automatic logic [3:0] sh_idx(input logic [7:0] a);
    case (a)
      A_NUL:   sh_idx = 4'h0;
      A_ALM:   sh_idx = 4'h1;
      A_UP_A:  sh_idx = 4'h2;
      A_UP_B:  sh_idx = 4'h3;
      A_LO_A:  sh_idx = 4'h4;
      A_LO_B:  sh_idx = 4'h5;
      A_DW_A:  sh_idx = 4'h6;
      A_DW_B:  sh_idx = 4'h7;
      default: sh_idx = 4'h8;
    endcase
  endfunction : sh_idx

  // Readback: shadowed bytes show what was written, not yet what is applied
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [3:0] i;
    i = sh_idx(a);
    if (!i[3])
      reg_read = sh_q[i[2:0]];
    else if (a == A_CFG)
      reg_read = cfg_q;
    else if (a == A_DCV_A)
      reg_read = dcv[7:0];
    else if (a == A_DCV_B)
      reg_read = dcv[15:8];
    else
      reg_read = 8'h00;
  endfunction : reg_read

  //////////////////////////////////////////////////////////////////////////////
  // Two flip-flops on every link pin before any logic reads it
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cs_s_q    <= 2'h3;
      ck_s_q    <= 2'h0;
      di_s_q    <= 2'h0;
      ck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      cs_s_q    <= {cs_s_q[0], link.cs_n};
      ck_s_q    <= {ck_s_q[0], link.sclk};
      di_s_q    <= {di_s_q[0], link.sdio};
      ck_prev_q <= ck_s_q[1];
      cs_prev_q <= cs_s_q[1];
    end
  end

  // Edges of the master clock, seen in the core clock domain
  assign ck_rise = ck_s_q[1] & ~ck_prev_q;
  assign ck_fall = ~ck_s_q[1] & ck_prev_q;
  assign cs_low  = ~cs_s_q[1];
  assign cs_fall = cs_low & cs_prev_q;
  assign sdi     = di_s_q[1];
  assign lsb     = cfg_q[B_LSB_FIRST];

  //////////////////////////////////////////////////////////////////////////////
  // Serial frame decoder
  always_comb
  begin
    ph_d   = ph_q;
    cnt_d  = cnt_q;
    ins_d  = ins_q;
    adr_d  = adr_q;
    rx_d   = rx_q;
    rb_d   = rb_q;
    left_d = left_q;
    rnw_d  = rnw_q;
    strm_d = strm_q;
    sdo_d  = sdo_q;
    oe_d   = oe_q;
    wr_en  = 1'b0;
    wr_dat = rx_q;
    if (!cs_low)
    begin
      oe_d = 1'b0;
      // A stall at a byte boundary of a non-streaming frame keeps its place; anything else ends the frame
      if (!(ph_q == PH_DATA && cnt_q == 4'h0 && !strm_q))
      begin
        ph_d  = PH_INSTR;
        cnt_d = 4'h0;
      end
    end
    else if (ck_rise)
    begin
      cnt_d = cnt_q + 4'h1;
      if (ph_q == PH_INSTR)
      begin
        ins_d[lsb ? cnt_q : ~cnt_q] = sdi;
        if (cnt_q == 4'hF)
        begin
          ph_d   = PH_DATA;
          cnt_d  = 4'h0;
          rnw_d  = ins_d[B_RNW];
          left_d = ins_d[B_LEN_HI:B_LEN_LO];
          strm_d = ins_d[B_LEN_HI] & ins_d[B_LEN_LO];
          adr_d  = ins_d[7:0];
          rb_d   = reg_read(ins_d[7:0]);
        end
      end
      else
      begin
        if (!rnw_q)
          rx_d[lsb ? cnt_q[2:0] : ~cnt_q[2:0]] = sdi;
        if (cnt_q[2:0] == 3'h7)
        begin
          cnt_d  = 4'h0;
          wr_en  = ~rnw_q;
          wr_dat = rx_d;
          adr_d  = adr_q + 8'h01;
          rb_d   = reg_read(adr_q + 8'h01);
          if (!strm_q)
          begin
            if (left_q == 2'h0)
              ph_d = PH_INSTR;
            else
              left_d = left_q - 2'h1;
          end
        end
      end
    end
    else if (ck_fall || cs_fall)
    begin
      // Resuming a stalled read needs its first bit before any clock edge
      oe_d = (ph_q == PH_DATA) && rnw_q;
      sdo_d = rb_q[lsb ? cnt_q[2:0] : ~cnt_q[2:0]];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ph_q   <= PH_INSTR;
      cnt_q  <= 4'h0;
      ins_q  <= 16'h0000;
      adr_q  <= 8'h00;
      rx_q   <= 8'h00;
      rb_q   <= 8'h00;
      left_q <= 2'h0;
      rnw_q  <= 1'b0;
      strm_q <= 1'b0;
      sdo_q  <= 1'b0;
      oe_q   <= 1'b0;
    end
    else
    begin
      ph_q   <= ph_d;
      cnt_q  <= cnt_d;
      ins_q  <= ins_d;
      adr_q  <= adr_d;
      rx_q   <= rx_d;
      rb_q   <= rb_d;
      left_q <= left_d;
      rnw_q  <= rnw_d;
      strm_q <= strm_d;
      sdo_q  <= sdo_d;
      oe_q   <= oe_d;
    end
  end

  assign link.d_sdo = sdo_q;
  assign link.d_oe  = oe_q;

  //////////////////////////////////////////////////////////////////////////////
  // Shadow slot of the address being written
  assign widx = sh_idx(adr_q);

  // Register writes; the transfer bit is never stored, so it reads as cleared
  always_comb
  begin
    cfg_d = cfg_q;
    sh_d  = sh_q;
    act_d = act_q;
    if (wr_en)
    begin
      if (!widx[3])
        sh_d[widx[2:0]] = wr_dat;
      else if (adr_q == A_CFG)
        cfg_d = wr_dat;
      else if (adr_q == A_XFER && wr_dat[B_XFER])
        act_d = sh_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_q <= R_BYTE;
      sh_q  <= {R_DWELL, {6{R_BYTE}}};
      act_q <= {R_DWELL, {6{R_BYTE}}};
    end
    else
    begin
      cfg_q <= cfg_d;
      sh_q  <= sh_d;
      act_q <= act_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Applied fields; an invalid k above 13 is treated as 13
  assign up_thr = {act_q[I_UP + 3'h1], act_q[I_UP]};
  assign lo_thr = {act_q[I_LO + 3'h1], act_q[I_LO]};
  assign dwell  = {act_q[I_DW + 3'h1], act_q[I_DW]};
  assign k      = (act_q[I_NUL][K_HI:K_LO] > K_MAX) ? K_MAX : act_q[I_NUL][K_HI:K_LO];
  assign shamt  = {1'b0, k} + K_BASE;

  // Magnitude ignores sign; codes are fractions of 2^13 full scale
  assign x16 = {{(OUT_W - SMP_W){sample_in[SMP_W-1]}}, sample_in};
  assign mag = sample_in[SMP_W-1] ? 16'h0000 - x16 : x16;
  assign xa  = {{(ACC_W - SMP_W - DC_FRAC){sample_in[SMP_W-1]}}, sample_in, {DC_FRAC{1'b0}}};
  assign err = xa - acc_q;
  assign dcv = acc_q[DC_FRAC+15:DC_FRAC];
  // Kept apart so the shift stays arithmetic; inside an unsigned sum it would go logical
  assign step = $signed(err) >>> shamt;

  // Alarm and offset nulling, one sample per core clock
  always_comb
  begin
    hit_d  = {hit_q[ALM_LAT-3:0], mag > up_thr};
    blw_d  = {blw_q[ALM_LAT-3:0], mag < lo_thr};
    flag_d = flag_q;
    dwc_d  = dwc_q;
    if (!act_q[I_ALM][B_ALM_EN])
    begin
      flag_d = 1'b0;
      dwc_d  = 16'h0000;
    end
    else if (hit_q[ALM_LAT-2])
    begin
      flag_d = 1'b1;
      dwc_d  = 16'h0000;
    end
    else if (flag_q && blw_q[ALM_LAT-2])
    begin
      // A dwell of zero behaves as one cycle
      if (dwc_q + 16'h0001 >= dwell || dwell == 16'h0000)
      begin
        flag_d = 1'b0;
        dwc_d  = 16'h0000;
      end
      else
        dwc_d = dwc_q + 16'h0001;
    end
    else
      dwc_d = 16'h0000;
    // First-order estimate; the output is not saturated
    acc_d = act_q[I_NUL][B_FREEZE] ? acc_q : acc_q + step;
    out_d = act_q[I_NUL][B_NUL_EN] ? x16 - dcv : x16;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hit_q  <= '0;
      blw_q  <= '0;
      flag_q <= 1'b0;
      dwc_q  <= 16'h0000;
      acc_q  <= '0;
      out_q  <= 16'h0000;
    end
    else
    begin
      hit_q  <= hit_d;
      blw_q  <= blw_d;
      flag_q <= flag_d;
      dwc_q  <= dwc_d;
      acc_q  <= acc_d;
      out_q  <= out_d;
    end
  end

  assign threshold_alarm_flag = flag_q;
  assign sample_out           = out_q;
endmodule : scd_device
`default_nettype wire

// ### verilog/scd_master.sv
// Serial master end: Wishbone command registers driving the three-wire link
`timescale 1ns/1ns
`default_nettype none
module scd_master
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Classic Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Three-wire link
  scd_link_if.master       link
);
  import scd_pkg::*;

  scd_mst_t    st_q;
  scd_mst_t    st_d;
  logic [15:0] ins_q;
  logic [15:0] ins_d;
  logic [31:0] tx_q;
  logic [31:0] tx_d;
  logic [31:0] rx_q;
  logic [31:0] rx_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic [1:0]  cfg_q;
  logic [1:0]  cfg_d;
  logic [3:0]  hc_q;
  logic [3:0]  hc_d;
  logic [5:0]  bit_q;
  logic [5:0]  bit_d;
  logic [5:0]  nxt;
  logic [5:0]  nbits;
  logic [2:0]  nbytes;
  logic        cs_q;
  logic        cs_d;
  logic        ck_q;
  logic        ck_d;
  logic        mo_q;
  logic        mo_d;
  logic        moe_q;
  logic        moe_d;
  logic        ack_q;
  logic        ack_d;
  logic [1:0]  di_s_q;
  logic        lsb;
  logic        rnw;
  logic        req;

  // Position of a data-phase bit inside the 32-bit data word
  function automatic logic [4:0] dpos(input logic [5:0] b);
    logic [5:0] d;
    d    = b - 6'h10;
    dpos = {d[4:3], lsb ? d[2:0] : ~d[2:0]};
  endfunction : dpos

  // Bit put on the wire for frame position b
  function automatic logic tx_bit(input logic [5:0] b);
    if (b < 6'h10)
      tx_bit = ins_q[lsb ? b[3:0] : ~b[3:0]];
    else
      tx_bit = tx_q[dpos(b)];
  endfunction : tx_bit

  assign lsb    = cfg_q[0];
  assign rnw    = ins_q[B_RNW];
  assign req    = wb_cyc_i & wb_stb_i;
  // Streaming code sends four bytes, then select rises to end the stream
  assign nbytes = {1'b0, ins_q[B_LEN_HI:B_LEN_LO]} + 3'h1;
  assign nbits  = 6'h10 + {nbytes, 3'h0};
  assign nxt    = bit_q + 6'h01;

  //////////////////////////////////////////////////////////////////////////////
  // Data pin synchroniser
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      di_s_q <= 2'h0;
    else
      di_s_q <= {di_s_q[0], link.sdio};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave and frame sequencer
  always_comb
  begin
    st_d  = st_q;
    ins_d = ins_q;
    tx_d  = tx_q;
    rx_d  = rx_q;
    cfg_d = cfg_q;
    hc_d  = hc_q + 4'h1;
    bit_d = bit_q;
    cs_d  = cs_q;
    ck_d  = ck_q;
    mo_d  = mo_q;
    moe_d = moe_q;
    ack_d = req & ~ack_q;
    dat_d = dat_q;
    // Read data is latched with the acknowledge
    if (req && !ack_q && !wb_we_i)
    begin
      case (wb_adr_i)
        W_INSTR: dat_d = {16'h0000, ins_q};
        W_TX:    dat_d = tx_q;
        W_RX:    dat_d = rx_q;
        W_STAT:  dat_d = {31'h00000000, st_q != M_IDLE};
        W_CFG:   dat_d = {30'h00000000, cfg_q};
        default: dat_d = 32'h00000000;
      endcase
    end
    unique case (st_q)
      M_IDLE:
      begin
        // Writes only while idle; the clock stays still between frames
        hc_d = 4'h0;
        if (req && ack_q && wb_we_i)
        begin
          if (wb_adr_i == W_TX)
          begin
            for (int i = 0; i < 4; i++)
              if (wb_sel_i[i])
                tx_d[i*8 +: 8] = wb_dat_i[i*8 +: 8];
          end
          else if (wb_adr_i == W_CFG && wb_sel_i[0])
            cfg_d = wb_dat_i[1:0];
          else if (wb_adr_i == W_INSTR)
          begin
            ins_d = wb_dat_i[15:0];
            st_d  = M_LEAD;
            cs_d  = 1'b0;
            bit_d = 6'h00;
            rx_d  = 32'h00000000;
          end
        end
      end
      M_LEAD:
        if (hc_q == HC_END)
        begin
          st_d  = M_LOW;
          hc_d  = 4'h0;
          mo_d  = tx_bit(bit_q);
          moe_d = (bit_q < 6'h10) || !rnw;
        end
      M_LOW:
        if (hc_q == HC_END)
        begin
          st_d = M_HIGH;
          hc_d = 4'h0;
          ck_d = 1'b1;
          if (rnw && bit_q >= 6'h10)
            rx_d[dpos(bit_q)] = di_s_q[1];
        end
      M_HIGH:
        if (hc_q == HC_END)
        begin
          hc_d  = 4'h0;
          ck_d  = 1'b0;
          bit_d = nxt;
          if (nxt == nbits || (cfg_q[1] && nxt >= 6'h10 && nxt[2:0] == 3'h0))
          begin
            st_d  = M_GAP;
            cs_d  = 1'b1;
            moe_d = 1'b0;
          end
          else
          begin
            st_d  = M_LOW;
            mo_d  = tx_bit(nxt);
            moe_d = (nxt < 6'h10) || !rnw;
          end
        end
      M_GAP:
        if (hc_q == GAP_END)
        begin
          hc_d = 4'h0;
          if (bit_q == nbits)
            st_d = M_IDLE;
          else
          begin
            st_d = M_LEAD;
            cs_d = 1'b0;
          end
        end
      default:
        st_d = M_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q  <= M_IDLE;
      ins_q <= 16'h0000;
      tx_q  <= 32'h00000000;
      rx_q  <= 32'h00000000;
      cfg_q <= 2'h0;
      hc_q  <= 4'h0;
      bit_q <= 6'h00;
      cs_q  <= 1'b1;
      ck_q  <= 1'b0;
      mo_q  <= 1'b0;
      moe_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end
    else
    begin
      st_q  <= st_d;
      ins_q <= ins_d;
      tx_q  <= tx_d;
      rx_q  <= rx_d;
      cfg_q <= cfg_d;
      hc_q  <= hc_d;
      bit_q <= bit_d;
      cs_q  <= cs_d;
      ck_q  <= ck_d;
      mo_q  <= mo_d;
      moe_q <= moe_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  assign link.cs_n  = cs_q;
  assign link.sclk  = ck_q;
  assign link.m_sdo = mo_q;
  assign link.m_oe  = moe_q;
  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = dat_q;
endmodule : scd_master
`default_nettype wire

// ### bench/scd_checker.sv
// Protocol checks on the three-wire link between master and device
`timescale 1ns/1ns
`default_nettype none
module scd_checker
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Link signals
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic m_sdo,
  input wire logic m_oe,
  input wire logic d_sdo,
  input wire logic d_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Frame steps: quiet lead-in, then fixed-width high phases
  sequence s_lead;
    !sclk [*8];
  endsequence
  sequence s_high;
    sclk [*8] ##1 !sclk;
  endsequence
  AST_LEAD: assert property ($fell(cs_n) |-> s_lead)
    else $error("sclk moved during lead-in");
  AST_HIGH: assert property ($rose(sclk) |-> s_high)
    else $error("sclk high phase not 8 cycles");
  // Only one party may drive the shared wire
  AST_CLASH: assert property (!(m_oe && d_oe))
    else $error("both ends drive sdio");
  AST_TURN: assert property ($rose(d_oe) |-> !sclk && !cs_n && !m_oe)
    else $error("device took sdio at a bad moment");
  // Deselected port lets go of the wire; clock rests low
  AST_HIZ: assert property (cs_n [*6] |-> !d_oe)
    else $error("device drives sdio while deselected");
  AST_IDLE: assert property (cs_n |-> !sclk)
    else $error("sclk toggles while deselected");
  // Data may only move while sclk is low
  AST_MHOLD: assert property (sclk && m_oe |-> $stable(m_sdo))
    else $error("master data moved while sclk high");
  AST_DHOLD: assert property (sclk && d_oe |-> $stable(d_sdo))
    else $error("device data moved while sclk high");
endmodule : scd_checker
`default_nettype wire

// ### bench/tb_serial_config_port_detect_dcc.sv
// Bench joining both ends: register traffic, alarm timing, offset filter
`timescale 1ns/1ns
`default_nettype none
module tb_serial_config_port_detect_dcc;
  import scd_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, fon = 1'b0;
  logic [7:0] adr = '0;
  logic [31:0] dat = '0, rd, wb_dat_o, rnd = 32'hE2B1;
  logic [13:0] fv = '0, sample_in = '0;
  logic [15:0] sample_out, v;
  logic wb_ack_o, flag;
  logic [63:0] q[$];
  logic [63:0] e;
  int failures = 0, check_count = 0;
  scd_link_if link ();
  scd_master u_scd_master (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link(link));
  scd_device u_scd_device (.core_clk(core_clk), .reset_n(reset_n), .link(link),
    .sample_in(sample_in), .sample_out(sample_out), .threshold_alarm_flag(flag));
  scd_checker u_scd_checker (.core_clk(core_clk), .reset_n(reset_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .m_sdo(link.m_sdo), .m_oe(link.m_oe), .d_sdo(link.d_sdo),
    .d_oe(link.d_oe));
  ////////////////////////////////////////
  // Free-running core clock
  always #5 core_clk = ~core_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // Small random noise keeps the magnitude under the lower threshold
  always @(posedge core_clk)
  begin
    rnd <= xs(rnd);
    sample_in <= fon ? fv : (rnd[13] ? -{4'h0, rnd[9:0]} : {4'h0, rnd[9:0]});
  end
  task automatic check(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      failures++;
      $display("mismatch %0t got %h expected %h", $time, g, x);
    end
  endtask : check
  // Read results are matched in order against the noted expectations
  always @(posedge core_clk)
    if (wb_ack_o === 1'b1 && we === 1'b0 && q.size() > 0)
    begin
      e = q.pop_front();
      check(wb_dat_o & e[63:32], e[31:0]);
    end
  ////////////////////////////////////////
  // One classic Wishbone cycle; waits for ack however long it takes
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // One link frame, then poll busy until the master is idle again
  task automatic frame(input logic r, input logic [1:0] n, input logic [7:0] a,
                       input logic [31:0] d);
    wb(1'b1, W_TX, d);
    wb(1'b1, W_INSTR, {16'h0000, r, n, 5'h00, a});
    do wb(1'b0, W_STAT, 32'h0); while (rd[0] !== 1'b0);
  endtask : frame
  task automatic rdb(input logic [1:0] n, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    frame(1'b1, n, a, 32'h0);
    // Let the last poll's acknowledge pass before the note is queued
    @(posedge core_clk);
    q.push_back({m, x});
    wb(1'b0, W_RX, 32'h0);
  endtask : rdb
  // One sample of the given value, then back to noise
  task automatic hit(input logic [13:0] x);
    fv <= x;
    fon <= 1'b1;
    @(posedge core_clk);
    fon <= 1'b0;
  endtask : hit
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // Hang guard, about two and a half times the expected run of some 11.5k cycles
  initial
  begin
    #300000;
    failures++;
    final_report();
  end
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    check(link.cs_n, 1'b1);
    check(link.d_oe, 1'b0);
    frame(1'b0, 2'h3, A_LO_A, 32'h00080800);
    wb(1'b1, W_CFG, 32'h2);
    frame(1'b0, 2'h1, A_UP_A, 32'h1000);
    wb(1'b1, W_CFG, 32'h0);
    frame(1'b0, 2'h0, A_ALM, 32'h1);
    hit(14'h1800);
    repeat (12) @(posedge core_clk);
    check(flag, 1'b0);
    frame(1'b0, 2'h0, A_XFER, 32'h1);
    rdb(2'h2, A_LO_A, 32'hFFFFFF, 32'h080800);
    rdb(2'h0, A_XFER, 32'hFF, 32'h0);
    rdb(2'h1, A_UP_A, 32'hFFFF, 32'h1000);
    frame(1'b0, 2'h0, A_CFG, 32'h40);
    wb(1'b1, W_CFG, 32'h1);
    rdb(2'h0, A_DW_A, 32'hFF, 32'h08);
    frame(1'b0, 2'h0, A_CFG, 32'h0);
    wb(1'b1, W_CFG, 32'h0);
    $display("test registers done");
    hit(14'h1800);
    repeat (6) @(posedge core_clk);
    hit(14'h0900);
    repeat (13) @(posedge core_clk);
    check(flag, 1'b1);
    repeat (16) @(posedge core_clk);
    check(flag, 1'b0);
    hit(14'h2800);
    repeat (9) @(posedge core_clk);
    check(flag, 1'b1);
    repeat (30) @(posedge core_clk);
    check(flag, 1'b0);
    $display("test alarm done");
    fv <= 14'h1000;
    fon <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(sample_out, 16'h1000);
    frame(1'b0, 2'h0, A_NUL, 32'h02);
    frame(1'b0, 2'h0, A_XFER, 32'h1);
    repeat (3000) @(posedge core_clk);
    check(sample_out !== 16'h1000, 1'b1);
    frame(1'b0, 2'h0, A_NUL, 32'h42);
    frame(1'b0, 2'h0, A_XFER, 32'h1);
    frame(1'b1, 2'h1, A_DCV_A, 32'h0);
    wb(1'b0, W_RX, 32'h0);
    v = rd[15:0];
    check(v > 16'h0280 && v < 16'h0500, 1'b1);
    repeat (500) @(posedge core_clk);
    frame(1'b1, 2'h1, A_DCV_A, 32'h0);
    wb(1'b0, W_RX, 32'h0);
    check(rd[15:0], v);
    check(sample_out, 16'h1000 - v);
    $display("test filter done");
    final_report();
  end
endmodule : tb_serial_config_port_detect_dcc
`default_nettype wire
